// ### include/fmdb_map.vh
// Address map, field positions and sizes of the fieldbus diagnostic bank
`ifndef FMDB_MAP_VH
`define FMDB_MAP_VH

// ---------------------------------------------------------------
// Word offsets
// ---------------------------------------------------------------
`define FMDB_ACYC_TX_BASE      16'h1680
`define FMDB_ACYC_TX_WORDS     16'h01f0
`define FMDB_PERR_FLAG_BASE    16'h1b58
`define FMDB_PERR_DET_BASE     16'h1b60
`define FMDB_PERR_DET_WORDS    16'h0040
`define FMDB_DIAG_FLAG_BASE    16'h1c20
`define FMDB_SNAP_REQ          16'h1c28
`define FMDB_SNAP_STATION      16'h1c29
`define FMDB_SNAP_DATA_BASE    16'h1c2a
`define FMDB_POP_REQ           16'h1ca8
`define FMDB_QUEUE_COUNT       16'h1ca9
`define FMDB_QUEUE_DATA_BASE   16'h1caa
`define FMDB_OVERVIEW_BASE     16'h1d28
`define FMDB_OVERVIEW_WORDS    16'h0080
`define FMDB_AUTO_ACK_BASE     16'h2250
`define FMDB_IRQ_STATUS        16'h2300
`define FMDB_IRQ_MASK          16'h2301
`define FMDB_FLAG_WORDS        16'h0004

// ---------------------------------------------------------------
// Interrupt status bit positions
// ---------------------------------------------------------------
`define FMDB_EV_PERR           0
`define FMDB_EV_DIAG           1
`define FMDB_EV_SNAP_DONE      2
`define FMDB_EV_POP_DONE       3
`define FMDB_EV_OVERFLOW       4
`define FMDB_EV_BITS           5

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define FMDB_RST_FLAGS         64'h0000000000000000
`define FMDB_RST_WORD          16'h0000

`endif

// ### verilog/fmdb_bank.v
// Buffer-memory register bank for fieldbus master diagnostics
//
// Summary of operation
// - Parameter mismatch at init sets slave flag
// - Parameter error details stored for host inspection
// - Received slave diagnostics set slave status flag
// - Snapshot request copies selected slave diagnostics
// - Snapshot area is read-only to host
// - Pop request moves oldest queued diagnostic out
// - Read-only queue count, capacity 64 entries
// - Read-only per-slave diagnostic overview words
// - Per-slave bit enables automatic alarm acknowledge
// - Auto acknowledge defaults to 1 for V1
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "fmdb_map.vh"

module fmdb_bank #(
    parameter SLAVES      = 64,
    parameter ENTRY_WORDS = 126,
    parameter QUEUE_DEPTH = 64
) (
    input  wire        clk_in,
    input  wire        rst_in,
    input  wire        ce_in,
    input  wire [15:0] addr_in,
    input  wire [15:0] wdata_in,
    input  wire        wr_in,
    input  wire        rd_in,
    output reg  [15:0] rdata_out,
    input  wire        perr_in,
    input  wire [5:0]  perr_slave_in,
    input  wire        perr_det_wr_in,
    input  wire [5:0]  perr_det_idx_in,
    input  wire [15:0] perr_det_word_in,
    input  wire        diag_wr_in,
    input  wire [5:0]  diag_slave_in,
    input  wire [6:0]  diag_idx_in,
    input  wire [15:0] diag_word_in,
    input  wire        diag_last_in,
    input  wire        ovw_wr_in,
    input  wire [6:0]  ovw_idx_in,
    input  wire [15:0] ovw_word_in,
    input  wire        cfg_load_in,
    input  wire [63:0] slave_v1_in,
    output reg  [63:0] auto_ack_out,
    output wire        irq_out
);

// ---------------------------------------------------------------
// Constants and storage
// ---------------------------------------------------------------
localparam [1:0]  ST_IDLE = 2'h0;
localparam [1:0]  ST_SNAP = 2'h1;
localparam [1:0]  ST_POP  = 2'h2;
localparam [12:0] EW      = ENTRY_WORDS;
localparam [6:0]  EW_LAST = ENTRY_WORDS - 1;
localparam [6:0]  QD      = QUEUE_DEPTH;

reg [15:0] acyc_mem  [0:495];
reg [15:0] perr_mem  [0:63];
reg [15:0] cur_mem   [0:SLAVES*ENTRY_WORDS-1];
reg [15:0] queue_mem [0:QUEUE_DEPTH*ENTRY_WORDS-1];
reg [15:0] snap_mem  [0:ENTRY_WORDS-1];
reg [15:0] pop_mem   [0:ENTRY_WORDS-1];
reg [15:0] ovw_mem   [0:127];

reg [63:0] perr_flags;
reg [63:0] diag_flags;
reg        snap_req;
reg [15:0] snap_station;
reg        pop_req;
reg [6:0]  q_count;
reg [5:0]  q_wptr;
reg [5:0]  q_rptr;
reg        q_drop;
reg [1:0]  state;
reg [6:0]  cidx;
reg [`FMDB_EV_BITS-1:0] irq_status;
reg [`FMDB_EV_BITS-1:0] irq_mask;

// ---------------------------------------------------------------
// Address decode
// ---------------------------------------------------------------
wire [15:0] off_acyc = addr_in - `FMDB_ACYC_TX_BASE;
wire [15:0] off_perr = addr_in - `FMDB_PERR_DET_BASE;
wire [15:0] off_snap = addr_in - `FMDB_SNAP_DATA_BASE;
wire [15:0] off_qdat = addr_in - `FMDB_QUEUE_DATA_BASE;
wire [15:0] off_ovw  = addr_in - `FMDB_OVERVIEW_BASE;
wire [15:0] off_pflg = addr_in - `FMDB_PERR_FLAG_BASE;
wire [15:0] off_dflg = addr_in - `FMDB_DIAG_FLAG_BASE;
wire [15:0] off_aack = addr_in - `FMDB_AUTO_ACK_BASE;

wire in_acyc = off_acyc < `FMDB_ACYC_TX_WORDS;
wire in_perr = off_perr < `FMDB_PERR_DET_WORDS;
wire in_snap = off_snap < ENTRY_WORDS;
wire in_qdat = off_qdat < ENTRY_WORDS;
wire in_ovw  = off_ovw  < `FMDB_OVERVIEW_WORDS;
wire in_pflg = off_pflg < `FMDB_FLAG_WORDS;
wire in_dflg = off_dflg < `FMDB_FLAG_WORDS;
wire in_aack = off_aack < `FMDB_FLAG_WORDS;

wire host_wr = ce_in & wr_in;

// ---------------------------------------------------------------
// Diagnostic intake and queue bookkeeping
// ---------------------------------------------------------------
wire        q_full    = (q_count == QD);
// A frame arriving while full is dropped whole, never half-written
wire        diag_drop = (diag_idx_in == 7'h00) ? q_full : q_drop;
wire        diag_ok   = diag_wr_in & ~diag_drop;
wire        q_push    = diag_ok & diag_last_in;
// A dropped frame still counts as received from its slave
wire        frame_end = diag_wr_in & diag_last_in;
wire        q_ovf     = frame_end & diag_drop;
wire        copy_last = (cidx == EW_LAST);
wire        snap_done = (state == ST_SNAP) & copy_last;
wire        pop_done  = (state == ST_POP) & copy_last;
wire        q_pop     = pop_done;
// Pop on an empty queue completes at once, readout left alone
wire        pop_empty = (state == ST_IDLE) & ~snap_req & pop_req
                        & (q_count == 7'h00);

// ---------------------------------------------------------------
// Frame and copy addressing
// ---------------------------------------------------------------
// Operands widened first so products never wrap below the array size
wire [12:0] slave_x   = {7'h00, diag_slave_in};
wire [12:0] widx_x    = {6'h00, diag_idx_in};
wire [12:0] station_x = {7'h00, snap_station[5:0]};
wire [12:0] wptr_x    = {7'h00, q_wptr};
wire [12:0] rptr_x    = {7'h00, q_rptr};
wire [12:0] cidx_x    = {6'h00, cidx};

wire [12:0] cur_wa  = slave_x * EW + widx_x;
wire [12:0] q_wa    = wptr_x * EW + widx_x;
wire [12:0] snap_ra = station_x * EW + cidx_x;
wire [12:0] pop_ra  = rptr_x * EW + cidx_x;

// ---------------------------------------------------------------
// Flag update helpers
// ---------------------------------------------------------------
function [63:0] put_word;
    input [63:0] cur;
    input [1:0]  k;
    input [15:0] d;
    begin
        put_word = cur;
        case (k)
            2'h0: put_word[15:0]  = d;
            2'h1: put_word[31:16] = d;
            2'h2: put_word[47:32] = d;
            default: put_word[63:48] = d;
        endcase
    end
endfunction

wire [63:0] perr_set = perr_in ? (64'h1 << perr_slave_in) : 64'h0;
wire [63:0] diag_set = frame_end ? (64'h1 << diag_slave_in) : 64'h0;

// Hardware set wins over a host write in the same cycle
wire [63:0] next_perr_flags =
    ((host_wr & in_pflg) ? put_word(perr_flags, off_pflg[1:0], wdata_in)
                         : perr_flags) | perr_set;
wire [63:0] next_diag_flags =
    ((host_wr & in_dflg) ? put_word(diag_flags, off_dflg[1:0], wdata_in)
                         : diag_flags) | diag_set;

wire [`FMDB_EV_BITS-1:0] irq_ev;
assign irq_ev[`FMDB_EV_PERR]      = perr_in;
assign irq_ev[`FMDB_EV_DIAG]      = q_push;
assign irq_ev[`FMDB_EV_SNAP_DONE] = snap_done;
assign irq_ev[`FMDB_EV_POP_DONE]  = pop_done | pop_empty;
assign irq_ev[`FMDB_EV_OVERFLOW]  = q_ovf;

wire irq_clr_hit = host_wr & (addr_in == `FMDB_IRQ_STATUS);
wire [`FMDB_EV_BITS-1:0] next_irq_status =
    (irq_status & ~(irq_clr_hit ? wdata_in[`FMDB_EV_BITS-1:0]
                                : {`FMDB_EV_BITS{1'b0}})) | irq_ev;

assign irq_out = |(irq_status & irq_mask);

// ---------------------------------------------------------------
// Control registers
// ---------------------------------------------------------------
always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
        perr_flags   <= `FMDB_RST_FLAGS;
        diag_flags   <= `FMDB_RST_FLAGS;
        auto_ack_out <= `FMDB_RST_FLAGS;
        snap_req     <= 1'b0;
        snap_station <= `FMDB_RST_WORD;
        pop_req      <= 1'b0;
        q_count      <= 7'h00;
        q_wptr       <= 6'h00;
        q_rptr       <= 6'h00;
        q_drop       <= 1'b0;
        state        <= ST_IDLE;
        cidx         <= 7'h00;
        irq_status   <= {`FMDB_EV_BITS{1'b0}};
        irq_mask     <= {`FMDB_EV_BITS{1'b0}};
    end else if (ce_in) begin
        perr_flags <= next_perr_flags;
        diag_flags <= next_diag_flags;
        irq_status <= next_irq_status;
        if (host_wr & (addr_in == `FMDB_IRQ_MASK)) begin
            irq_mask <= wdata_in[`FMDB_EV_BITS-1:0];
        end
        // V1 slaves come up with automatic acknowledge on
        if (cfg_load_in) begin
            auto_ack_out <= slave_v1_in;
        end else if (host_wr & in_aack) begin
            auto_ack_out <= put_word(auto_ack_out, off_aack[1:0],
                                     wdata_in);
        end
        if (host_wr & (addr_in == `FMDB_SNAP_STATION)) begin
            snap_station <= wdata_in;
        end
        // Queue pointers and occupancy
        // Pointers wrap freely; the counter tells full from empty
        if (diag_wr_in & (diag_idx_in == 7'h00)) begin
            q_drop <= q_full;
        end
        if (q_push) begin
            q_wptr <= q_wptr + 6'h01;
        end
        if (q_pop) begin
            q_rptr <= q_rptr + 6'h01;
        end
        if (q_push & ~q_pop) begin
            q_count <= q_count + 7'h01;
        end else if (q_pop & ~q_push) begin
            q_count <= q_count - 7'h01;
        end
        // Request bits: host sets, completion clears
        if (snap_done) begin
            snap_req <= 1'b0;
        end else if (host_wr & (addr_in == `FMDB_SNAP_REQ)) begin
            snap_req <= wdata_in[0];
        end
        if (pop_done | pop_empty) begin
            pop_req <= 1'b0;
        end else if (host_wr & (addr_in == `FMDB_POP_REQ)) begin
            pop_req <= wdata_in[0];
        end
        // Copy engine, one word per cycle; snapshot has priority
        case (state)
            ST_IDLE: begin
                cidx <= 7'h00;
                if (snap_req) begin
                    state <= ST_SNAP;
                end else if (pop_req & (q_count != 7'h00)) begin
                    state <= ST_POP;
                end
            end
            ST_SNAP, ST_POP: begin
                if (copy_last) begin
                    state <= ST_IDLE;
                    cidx  <= 7'h00;
                end else begin
                    cidx <= cidx + 7'h01;
                end
            end
            default: begin
                state <= ST_IDLE;
            end
        endcase
    end
end

// ---------------------------------------------------------------
// Memories written by the host, the fieldbus side and the copy engine
// ---------------------------------------------------------------
always @(posedge clk_in) begin
    if (host_wr & in_acyc) begin
        acyc_mem[off_acyc[8:0]] <= wdata_in;
    end
end

// Fieldbus-side detail writes take priority over the host
always @(posedge clk_in) begin
    if (ce_in & perr_det_wr_in) begin
        perr_mem[perr_det_idx_in] <= perr_det_word_in;
    end else if (host_wr & in_perr) begin
        perr_mem[off_perr[5:0]] <= wdata_in;
    end
end

always @(posedge clk_in) begin
    if (ce_in & diag_wr_in) begin
        cur_mem[cur_wa] <= diag_word_in;
    end
end

always @(posedge clk_in) begin
    if (ce_in & diag_ok) begin
        queue_mem[q_wa] <= diag_word_in;
    end
end

always @(posedge clk_in) begin
    if (ce_in & ovw_wr_in) begin
        ovw_mem[ovw_idx_in] <= ovw_word_in;
    end
end

// A host read during a copy may see old and new words mixed
// Copy targets are written only by the engine, never by the host
always @(posedge clk_in) begin
    if (ce_in & (state == ST_SNAP)) begin
        snap_mem[cidx] <= cur_mem[snap_ra];
    end
end

always @(posedge clk_in) begin
    if (ce_in & (state == ST_POP)) begin
        pop_mem[cidx] <= queue_mem[pop_ra];
    end
end

// ---------------------------------------------------------------
// Read path
// ---------------------------------------------------------------
always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
        rdata_out <= `FMDB_RST_WORD;
    end else if (ce_in) begin
        // Idle cycles return zero so no stale word lingers
        if (!rd_in) begin
            rdata_out <= `FMDB_RST_WORD;
        end else if (in_acyc) begin
            rdata_out <= acyc_mem[off_acyc[8:0]];
        end else if (in_pflg) begin
            rdata_out <= perr_flags[{off_pflg[1:0], 4'h0} +: 16];
        end else if (in_perr) begin
            rdata_out <= perr_mem[off_perr[5:0]];
        end else if (in_dflg) begin
            rdata_out <= diag_flags[{off_dflg[1:0], 4'h0} +: 16];
        end else if (addr_in == `FMDB_SNAP_REQ) begin
            rdata_out <= {15'h0000, snap_req};
        end else if (addr_in == `FMDB_SNAP_STATION) begin
            rdata_out <= snap_station;
        end else if (in_snap) begin
            rdata_out <= snap_mem[off_snap[6:0]];
        end else if (addr_in == `FMDB_POP_REQ) begin
            rdata_out <= {15'h0000, pop_req};
        end else if (addr_in == `FMDB_QUEUE_COUNT) begin
            rdata_out <= {9'h000, q_count};
        end else if (in_qdat) begin
            rdata_out <= pop_mem[off_qdat[6:0]];
        end else if (in_ovw) begin
            rdata_out <= ovw_mem[off_ovw[6:0]];
        end else if (in_aack) begin
            rdata_out <= auto_ack_out[{off_aack[1:0], 4'h0} +: 16];
        end else if (addr_in == `FMDB_IRQ_STATUS) begin
            rdata_out <= {11'h000, irq_status};
        end else if (addr_in == `FMDB_IRQ_MASK) begin
            rdata_out <= {11'h000, irq_mask};
        end else begin
            rdata_out <= `FMDB_RST_WORD;
        end
    end
end

endmodule // fmdb_bank

`default_nettype wire

// ### verification/fmdb_bank_props.sv
// Concurrent checks on the host port of the diagnostic bank
`timescale 1ns/10ps
`default_nettype none
`include "fmdb_map.vh"
module fmdb_bank_props (
    input wire logic        clk_in,
    input wire logic        rst_in,
    input wire logic        ce_in,
    input wire logic [15:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic        wr_in,
    input wire logic        rd_in,
    input wire logic [15:0] rdata_out,
    input wire logic        cfg_load_in,
    input wire logic [63:0] slave_v1_in,
    input wire logic [63:0] auto_ack_out,
    input wire logic        irq_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    // ----------------------------------------
    // Host port
    // ----------------------------------------
    rd_idle_a: assert property (
        ce_in && !rd_in |=> rdata_out == 16'h0000)
        else $error("Read data not cleared");
    count_max_a: assert property (
        ce_in && rd_in && addr_in == `FMDB_QUEUE_COUNT
        |=> rdata_out <= 16'h0040) else $error("Queue count too big");
    pop_bit_a: assert property (
        ce_in && rd_in && addr_in == `FMDB_POP_REQ
        |=> rdata_out[15:1] == 15'h0000) else $error("Pop word bad");
    snap_busy_a: assert property (
        ce_in && wr_in && addr_in == `FMDB_SNAP_REQ && wdata_in[0]
        ##[1:2] ce_in && rd_in && addr_in == `FMDB_SNAP_REQ
        |=> rdata_out == 16'h0001) else $error("Snapshot bit lost");
    // ----------------------------------------
    // Auto acknowledge, interrupt and read data hold
    // ----------------------------------------
    ack_load_a: assert property (
        ce_in && cfg_load_in |=> auto_ack_out == $past(slave_v1_in))
        else $error("Auto ack not loaded");
    ack_write_a: assert property (
        ce_in && wr_in && !cfg_load_in
        && addr_in == `FMDB_AUTO_ACK_BASE + 16'h0002
        |=> auto_ack_out[47:32] == $past(wdata_in))
        else $error("Auto ack word not written");
    ack_hold_a: assert property (
        !(ce_in && (cfg_load_in || wr_in && addr_in[15:2] == 14'h0894))
        |=> $stable(auto_ack_out)) else $error("Auto ack moved");
    frozen_a: assert property (
        !ce_in |=> $stable(rdata_out)) else $error("Read data moved");
    mask_off_a: assert property (
        ce_in && wr_in && addr_in == `FMDB_IRQ_MASK && wdata_in == 0
        |=> !irq_out) else $error("Masked interrupt high");
endmodule // fmdb_bank_props
bind fmdb_bank fmdb_bank_props fmdb_bank_props_inst (.clk_in(clk_in),
    .rst_in(rst_in), .ce_in(ce_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .cfg_load_in(cfg_load_in),
    .slave_v1_in(slave_v1_in), .auto_ack_out(auto_ack_out),
    .irq_out(irq_out));
`default_nettype wire

// ### verification/fmdb_slave_model.sv
// Fieldbus side model: slaves sending diagnostics and errors
`timescale 1ns/10ps
`default_nettype none
module fmdb_slave_model (
    input  wire logic   clk_in,
    output logic [5:0]  slave_out,
    output logic [6:0]  idx_out,
    output logic [15:0] word_out,
    output logic        perr_out,
    output logic        diag_out,
    output logic        last_out,
    output logic        ovw_out,
    output logic        cfg_out,
    output logic [63:0] v1_out
);
    initial {slave_out, idx_out, word_out, perr_out, diag_out,
             last_out, ovw_out, cfg_out, v1_out} = 0;
    // Frames always start at word 0, one word a cycle
    task frame(input [5:0] s);
        integer k;
        for (k = 0; k < 126; k = k + 1) begin
            @(posedge clk_in);
            diag_out <= 1'b1;
            slave_out <= s;
            idx_out <= k[6:0];
            word_out <= {s, 3'h5, k[6:0]};
            last_out <= (k == 125);
        end
        @(posedge clk_in);
        diag_out <= 1'b0;
        last_out <= 1'b0;
        word_out <= ~word_out;
    endtask
    // Error flag and its detail word arrive together
    task perr(input [5:0] s, input [5:0] i, input [15:0] w);
        @(posedge clk_in);
        perr_out <= 1'b1;
        slave_out <= s;
        idx_out <= {1'b0, i};
        word_out <= w;
        @(posedge clk_in);
        perr_out <= 1'b0;
        word_out <= ~w;
    endtask
    task ovw(input [6:0] i, input [15:0] w);
        @(posedge clk_in);
        ovw_out <= 1'b1;
        idx_out <= i;
        word_out <= w;
        @(posedge clk_in);
        ovw_out <= 1'b0;
        word_out <= ~w;
    endtask
    task cfg(input [63:0] v);
        @(posedge clk_in);
        cfg_out <= 1'b1;
        v1_out <= v;
        @(posedge clk_in);
        cfg_out <= 1'b0;
    endtask
endmodule // fmdb_slave_model
`default_nettype wire

// ### verification/tb_fmdb_bank.sv
// Self-checking bench for the diagnostic register bank
`timescale 1ns/10ps
`default_nettype none
`include "fmdb_map.vh"
module tb_fmdb_bank;
    logic        clk, rst, ce, wr, rd;
    logic [15:0] addr, wdata, v;
    wire  [15:0] rdata, word;
    wire  [63:0] aack, v1;
    wire  [6:0]  idx;
    wire  [5:0]  sl;
    wire         irq, perr, diag, last, ovw, cfg;
    integer      bad_count = 0, samples_checked = 0, cycles = 0, i;
    fmdb_bank fmdb_bank_inst (.clk_in(clk), .rst_in(rst), .ce_in(ce),
        .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
        .rdata_out(rdata), .perr_in(perr), .perr_slave_in(sl),
        .perr_det_wr_in(perr), .perr_det_idx_in(idx[5:0]),
        .perr_det_word_in(word), .diag_wr_in(diag), .diag_slave_in(sl),
        .diag_idx_in(idx), .diag_word_in(word), .diag_last_in(last),
        .ovw_wr_in(ovw), .ovw_idx_in(idx), .ovw_word_in(word),
        .cfg_load_in(cfg), .slave_v1_in(v1), .auto_ack_out(aack),
        .irq_out(irq));
    fmdb_slave_model m (.clk_in(clk), .slave_out(sl), .idx_out(idx),
        .word_out(word), .perr_out(perr), .diag_out(diag),
        .last_out(last), .ovw_out(ovw), .cfg_out(cfg), .v1_out(v1));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Hang guard: the overflow fill dominates the run time
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count = bad_count + 1;
            test_done;
        end
    end
    task wrr(input [15:0] a, input [15:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task rdr(input [15:0] a, output [15:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task chk(input [63:0] g, input [63:0] e);
        samples_checked = samples_checked + 1;
        if (g !== e) begin
            bad_count = bad_count + 1;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task tend(input [8*8-1:0] n);
        $display("test %0s done", n);
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        {rst, ce, addr, wdata, wr, rd} = {2'b11, 34'h0};
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rdr(`FMDB_QUEUE_COUNT, v);
        chk(v, 16'h0000);
        chk(aack, 64'h0);
        wrr(`FMDB_ACYC_TX_BASE + 16'h01ef, 16'hc3a1);
        rdr(`FMDB_ACYC_TX_BASE + 16'h01ef, v);
        chk(v, 16'hc3a1);
        rdr(16'h0000, v);
        chk(v, 16'h0000);
        wrr(`FMDB_POP_REQ, 16'h0001);
        rdr(`FMDB_POP_REQ, v);
        chk(v, 16'h0000);
        rdr(`FMDB_IRQ_STATUS, v);
        chk(v, 16'h0008);
        wrr(`FMDB_IRQ_STATUS, 16'h0008);
        tend("reset");
        wrr(`FMDB_IRQ_MASK, 16'h001f);
        m.perr(6'h14, 6'h03, 16'hbeef);
        rdr(`FMDB_PERR_FLAG_BASE + 16'h0001, v);
        chk(v, 16'h0010);
        rdr(`FMDB_PERR_DET_BASE + 16'h0003, v);
        chk(v, 16'hbeef);
        chk(irq, 1'b1);
        wrr(`FMDB_IRQ_STATUS, 16'h0001);
        @(posedge clk);
        chk(irq, 1'b0);
        tend("perr");
        m.frame(6'h05);
        m.frame(6'h09);
        rdr(`FMDB_DIAG_FLAG_BASE, v);
        chk(v, 16'h0220);
        rdr(`FMDB_QUEUE_COUNT, v);
        chk(v, 16'h0002);
        rdr(`FMDB_IRQ_STATUS, v);
        chk(v, 16'h0002);
        tend("diag");
        wrr(`FMDB_SNAP_STATION, 16'h0005);
        wrr(`FMDB_SNAP_REQ, 16'h0001);
        rdr(`FMDB_SNAP_REQ, v);
        chk(v, 16'h0001);
        repeat (130) @(posedge clk);
        rdr(`FMDB_SNAP_REQ, v);
        chk(v, 16'h0000);
        rdr(`FMDB_SNAP_DATA_BASE + 16'h007d, v);
        chk(v, {6'h05, 3'h5, 7'h7d});
        wrr(`FMDB_SNAP_DATA_BASE, 16'h0000);
        rdr(`FMDB_SNAP_DATA_BASE, v);
        chk(v, {6'h05, 3'h5, 7'h00});
        tend("snap");
        wrr(`FMDB_POP_REQ, 16'h0001);
        repeat (130) @(posedge clk);
        rdr(`FMDB_POP_REQ, v);
        chk(v, 16'h0000);
        rdr(`FMDB_QUEUE_DATA_BASE + 16'h007d, v);
        chk(v, {6'h05, 3'h5, 7'h7d});
        wrr(`FMDB_QUEUE_COUNT, 16'h0007);
        rdr(`FMDB_QUEUE_COUNT, v);
        chk(v, 16'h0001);
        tend("pop");
        wrr(`FMDB_IRQ_STATUS, 16'h001f);
        for (i = 0; i < 64; i = i + 1)
            m.frame(i[5:0]);
        rdr(`FMDB_QUEUE_COUNT, v);
        chk(v, 16'h0040);
        rdr(`FMDB_IRQ_STATUS, v);
        chk(v, 16'h0012);
        rdr(`FMDB_DIAG_FLAG_BASE + 16'h0003, v);
        chk(v, 16'hffff);
        tend("full");
        m.ovw(7'h07, 16'h5a5a);
        wrr(`FMDB_OVERVIEW_BASE + 16'h0007, 16'h0000);
        rdr(`FMDB_OVERVIEW_BASE + 16'h0007, v);
        chk(v, 16'h5a5a);
        m.cfg(64'h000000000000a5a5);
        @(posedge clk);
        chk(aack, 64'h000000000000a5a5);
        wrr(`FMDB_AUTO_ACK_BASE + 16'h0002, 16'h1234);
        @(posedge clk);
        chk(aack, 64'h000012340000a5a5);
        ce <= 1'b0;
        wrr(`FMDB_IRQ_MASK, 16'h0000);
        ce <= 1'b1;
        @(posedge clk);
        chk(irq, 1'b1);
        wrr(`FMDB_IRQ_MASK, 16'h0000);
        @(posedge clk);
        chk(irq, 1'b0);
        tend("ack");
        test_done;
    end
endmodule // tb_fmdb_bank
`default_nettype wire
